// [pkg/iop_pkg.sv]
// package: i/o register map, opcodes and widths for the i/o port register block
package iop_pkg;
    localparam int          IOP_DATA_W        = 8;
    localparam int          IOP_ADDR_W        = 8;
    localparam int          IOP_NUM_PORTS     = 4;
    localparam logic [7:0]  IOP_ADDR_P0_DATA  = 8'h00;
    localparam logic [7:0]  IOP_ADDR_P1_DATA  = 8'h01;
    localparam logic [7:0]  IOP_ADDR_P2_DATA  = 8'h02;
    localparam logic [7:0]  IOP_ADDR_P3_DATA  = 8'h03;
    localparam logic [7:0]  IOP_ADDR_P0_IRQEN = 8'h04;
    localparam logic [7:0]  IOP_ADDR_P1_IRQEN = 8'h05;
    localparam logic [7:0]  IOP_ADDR_P2_IRQEN = 8'h06;
    localparam logic [7:0]  IOP_ADDR_P3_IRQEN = 8'h07;
    localparam logic [7:0]  IOP_DATA_RESET    = 8'h00;
    localparam logic [7:0]  IOP_IRQEN_RESET   = 8'h00;
    localparam logic [7:0]  IOP_UNMAPPED_RD   = 8'h00;
    localparam logic [7:0]  IOP_OP_READ       = 8'h29;
    localparam logic [7:0]  IOP_OP_WRITE      = 8'h2A;
    localparam logic [7:0]  IOP_OP_WRITE_X    = 8'h2B;
    typedef enum logic [1:0] {
        IOP_CMD_NONE   = 2'b00,
        IOP_CMD_READ   = 2'b01,
        IOP_CMD_WRITE  = 2'b11,
        IOP_CMD_WRITEX = 2'b10
    } iop_cmd_type;
endpackage

// [verilog/iop_decode.sv]
// instruction decoder: opcode to i/o command and effective port address
`timescale 1ns/10ps
`default_nettype none
module iop_decode (
    input  wire logic [7:0]           opcode_i,
    input  wire logic [7:0]           addr_field_i,
    input  wire logic [7:0]           index_x_i,
    output iop_pkg::iop_cmd_type      cmd_o,
    output logic [7:0]                eff_addr_o
);
    import iop_pkg::*;

    always_comb begin
        cmd_o      = IOP_CMD_NONE;
        eff_addr_o = addr_field_i;
        case (opcode_i)
            IOP_OP_READ: begin
                cmd_o = IOP_CMD_READ;
            end
            IOP_OP_WRITE: begin
                cmd_o = IOP_CMD_WRITE;
            end
            IOP_OP_WRITE_X: begin
                cmd_o = IOP_CMD_WRITEX;
                // address wraps modulo 256; field 0 leaves x alone
                eff_addr_o = 8'(addr_field_i + index_x_i);
            end
            default: begin
                cmd_o = IOP_CMD_NONE;
            end
        endcase
    end
endmodule // iop_decode
`default_nettype wire

// [verilog/iop_regs.sv]
// i/o register bank: gpio port data and per-port interrupt enables
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - read returns addressed register to accumulator
// - direct write stores accumulator at address
// - indexed write address is field plus x
// - zero address field selects by x alone
// - write-only irq enables per port follow data
module iop_regs (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 instr_valid_i,
    input  wire logic [7:0]           opcode_i,
    input  wire logic [7:0]           addr_field_i,
    input  wire logic [7:0]           index_x_i,
    input  wire logic [7:0]           acc_i,
    output logic [7:0]                rd_data_o,
    output logic                      rd_valid_o,
    output logic [31:0]               port_data_o,
    output logic [31:0]               port_irq_en_o
);
    import iop_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    iop_cmd_type cmd;
    logic [7:0]  eff_addr;
    logic [7:0]  port_data [IOP_NUM_PORTS];
    logic [7:0]  irq_en    [IOP_NUM_PORTS];
    logic        wr_en;

    iop_decode u_decode (
        .opcode_i     (opcode_i),
        .addr_field_i (addr_field_i),
        .index_x_i    (index_x_i),
        .cmd_o        (cmd),
        .eff_addr_o   (eff_addr)
    );

    function automatic logic is_data_addr(input logic [7:0] a);
        return a <= IOP_ADDR_P3_DATA;
    endfunction

    function automatic logic is_irqen_addr(input logic [7:0] a);
        return (a >= IOP_ADDR_P0_IRQEN) && (a <= IOP_ADDR_P3_IRQEN);
    endfunction

    // both write forms share one path; reserved addresses simply miss decode
    assign wr_en = instr_valid_i && (cmd == IOP_CMD_WRITE || cmd == IOP_CMD_WRITEX);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < IOP_NUM_PORTS; i++) begin
                port_data[i] <= IOP_DATA_RESET;
            end
        end else if (wr_en && is_data_addr(eff_addr)) begin
            port_data[eff_addr[1:0]] <= acc_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < IOP_NUM_PORTS; i++) begin
                irq_en[i] <= IOP_IRQEN_RESET;
            end
        end else if (wr_en && is_irqen_addr(eff_addr)) begin
            irq_en[eff_addr[1:0]] <= acc_i;
        end
    end

    // read answers one cycle after the instruction; enables are write-only
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_data_o  <= IOP_UNMAPPED_RD;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= instr_valid_i && (cmd == IOP_CMD_READ);
            if (instr_valid_i && cmd == IOP_CMD_READ) begin
                if (is_data_addr(eff_addr)) begin
                    rd_data_o <= port_data[eff_addr[1:0]];
                end else begin
                    rd_data_o <= IOP_UNMAPPED_RD;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < IOP_NUM_PORTS; i++) begin
            port_data_o[i*8 +: 8]   = port_data[i];
            port_irq_en_o[i*8 +: 8] = irq_en[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_read_returns: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_READ && addr_field_i <= IOP_ADDR_P3_DATA
        |=> rd_valid_o && rd_data_o == $past(port_data_o[addr_field_i[1:0]*8 +: 8]))
        else $error("read data mismatch");

    a_direct_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE && addr_field_i <= IOP_ADDR_P3_DATA
        |=> port_data_o[$past(addr_field_i[1:0])*8 +: 8] == $past(acc_i))
        else $error("direct write not stored");

    a_indexed_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE_X
        && 8'(addr_field_i + index_x_i) <= IOP_ADDR_P3_DATA
        |=> port_data_o[$past(2'(addr_field_i + index_x_i))*8 +: 8] == $past(acc_i))
        else $error("indexed write not stored");

    a_zero_field: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE_X && addr_field_i == 8'h00
        && index_x_i >= IOP_ADDR_P0_IRQEN && index_x_i <= IOP_ADDR_P3_IRQEN
        |=> port_irq_en_o[$past(index_x_i[1:0])*8 +: 8] == $past(acc_i))
        else $error("index-only select failed");

    a_irqen_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE && addr_field_i >= IOP_ADDR_P0_IRQEN
        && addr_field_i <= IOP_ADDR_P3_IRQEN
        |=> port_irq_en_o[$past(addr_field_i[1:0])*8 +: 8] == $past(acc_i)
            && $stable(port_data_o))
        else $error("irq enable write wrong");

    a_unmapped_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && (opcode_i == IOP_OP_WRITE || opcode_i == IOP_OP_READ)
        && addr_field_i > IOP_ADDR_P3_IRQEN
        |=> $stable(port_data_o) && $stable(port_irq_en_o))
        else $error("unmapped write changed state");

    a_no_instr_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !instr_valid_i |=> !rd_valid_o && $stable(port_data_o) && $stable(port_irq_en_o))
        else $error("state changed without instruction");

    a_read_no_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_READ
        |=> $stable(port_data_o) && $stable(port_irq_en_o))
        else $error("read altered registers");

    ////////////////////////////////////////////////////////////////////////////////
    // read path: pulse only after a read, data held between reads
    a_read_pulse_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !(instr_valid_i && opcode_i == IOP_OP_READ)
        |=> !rd_valid_o)
        else $error("read valid without a read");

    a_read_data_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !(instr_valid_i && opcode_i == IOP_OP_READ)
        |=> $stable(rd_data_o))
        else $error("read data moved without a read");

    a_read_unmapped: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_READ && addr_field_i > IOP_ADDR_P3_DATA
        |=> rd_valid_o && rd_data_o == IOP_UNMAPPED_RD)
        else $error("unmapped read not fixed value");

    // enables never read back, so software cannot learn them through the bank
    a_irqen_no_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_READ
        && addr_field_i >= IOP_ADDR_P0_IRQEN && addr_field_i <= IOP_ADDR_P3_IRQEN
        |=> rd_data_o == IOP_UNMAPPED_RD)
        else $error("irq enable read back");

    ////////////////////////////////////////////////////////////////////////////////
    // write paths: at most one byte moves, nothing else
    a_indexed_irqen: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE_X
        && 8'(addr_field_i + index_x_i) >= IOP_ADDR_P0_IRQEN
        && 8'(addr_field_i + index_x_i) <= IOP_ADDR_P3_IRQEN
        |=> port_irq_en_o[$past(2'(addr_field_i + index_x_i))*8 +: 8] == $past(acc_i)
            && $stable(port_data_o))
        else $error("indexed enable write wrong");

    a_indexed_keeps_en: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE_X
        && 8'(addr_field_i + index_x_i) <= IOP_ADDR_P3_DATA
        |=> $stable(port_irq_en_o))
        else $error("indexed data write touched enables");

    a_indexed_wraps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE_X
        && {1'b0, addr_field_i} + {1'b0, index_x_i} > 9'h0FF
        && 8'(addr_field_i + index_x_i) <= IOP_ADDR_P3_DATA
        |=> port_data_o[$past(2'(addr_field_i + index_x_i))*8 +: 8] == $past(acc_i))
        else $error("indexed address did not wrap");

    a_zero_field_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE_X && addr_field_i == 8'h00
        && index_x_i <= IOP_ADDR_P3_DATA
        |=> port_data_o[$past(index_x_i[1:0])*8 +: 8] == $past(acc_i))
        else $error("index-only data select failed");

    a_direct_keeps_en: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE && addr_field_i <= IOP_ADDR_P3_DATA
        |=> $stable(port_irq_en_o))
        else $error("direct data write touched enables");

    a_direct_others_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE && addr_field_i <= IOP_ADDR_P3_DATA
        |=> (port_data_o & ~(32'h0000_00FF << ($past(addr_field_i[1:0]) * 8)))
            == ($past(port_data_o) & ~(32'h0000_00FF << ($past(addr_field_i[1:0]) * 8))))
        else $error("direct write hit another port");

    a_enable_keeps_others: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i == IOP_OP_WRITE && addr_field_i >= IOP_ADDR_P0_IRQEN
        && addr_field_i <= IOP_ADDR_P3_IRQEN
        |=> (port_irq_en_o & ~(32'h0000_00FF << ($past(addr_field_i[1:0]) * 8)))
            == ($past(port_irq_en_o) & ~(32'h0000_00FF << ($past(addr_field_i[1:0]) * 8))))
        else $error("enable write hit another port");

    a_write_no_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && (opcode_i == IOP_OP_WRITE || opcode_i == IOP_OP_WRITE_X)
        |=> !rd_valid_o && $stable(rd_data_o))
        else $error("write disturbed read path");

    // unknown opcodes must be harmless: the core shares this bus with other ops
    a_unknown_op_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        instr_valid_i && opcode_i != IOP_OP_READ && opcode_i != IOP_OP_WRITE
        && opcode_i != IOP_OP_WRITE_X
        |=> !rd_valid_o && $stable(port_data_o) && $stable(port_irq_en_o))
        else $error("unknown opcode changed state");
endmodule // iop_regs
`default_nettype wire

// [tb/iop_core_model.sv]
// core model: issues i/o instructions toward the register bank
`timescale 1ns/10ps
`default_nettype none
module iop_core_model (
    input  wire logic       clk_sys_i,
    output logic            instr_valid_o,
    output logic [7:0]      opcode_o,
    output logic [7:0]      addr_field_o,
    output logic [7:0]      index_x_o,
    output logic [7:0]      acc_o
);
    import iop_pkg::*;
    initial begin
        {instr_valid_o, opcode_o, addr_field_o, index_x_o, acc_o} = 33'h0;
    end
    // acc is taken whole; callers pass bytes with no reserved bits set
    task issue(input logic [7:0] op, input logic [7:0] a, input logic [7:0] x,
               input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        // stores outside the map go out as opcode 00, still marked valid
        if (op != IOP_OP_READ && a + (op == IOP_OP_WRITE_X ? x : 8'h00) > 8'h07) begin
            op = 8'h00;
        end
        {instr_valid_o, opcode_o, addr_field_o, index_x_o, acc_o} = {1'b1, op, a, x, d};
    endtask
    task idle();
        @(posedge clk_sys_i);
        #1;
        // idle lines flip so a bank that ignores valid gets caught
        {instr_valid_o, opcode_o, addr_field_o, index_x_o, acc_o} =
            {1'b0, ~opcode_o, ~addr_field_o, ~index_x_o, ~acc_o};
    endtask
endmodule // iop_core_model
`default_nettype wire

// [tb/io_port_register_access_test.sv]
// testbench: i/o register bank driven by the core model
`timescale 1ns/10ps
`default_nettype none
module io_port_register_access_test;
    import iop_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic        instr_valid;
    logic [7:0]  opcode, addr_field, index_x, acc, rd_data;
    logic        rd_valid;
    logic [31:0] port_data, port_irq_en;
    int          fail_count  = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    iop_regs i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid),
        .opcode_i(opcode), .addr_field_i(addr_field), .index_x_i(index_x), .acc_i(acc),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .port_data_o(port_data),
        .port_irq_en_o(port_irq_en));
    iop_core_model i_core (.clk_sys_i(clk_sys_i), .instr_valid_o(instr_valid),
        .opcode_o(opcode), .addr_field_o(addr_field), .index_x_o(index_x), .acc_o(acc));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // hang guard: the whole run needs well under 200 cycles
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fail_count++;
            close_out();
        end
    end
    task rd(input logic [7:0] a, input logic [7:0] exp);
        i_core.issue(IOP_OP_READ, a, 8'h00, 8'h00);
        i_core.idle();
        check({31'h0, rd_valid}, 32'h1);
        check({24'h0, rd_data}, {24'h0, exp});
        @(posedge clk_sys_i);
        #1;
        check({31'h0, rd_valid}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_direct();
        for (int n = 0; n < 4; n++) begin
            i_core.issue(IOP_OP_WRITE, 8'(n), 8'h3C, 8'(17 * (n + 1)));
        end
        i_core.idle();
        check(port_data, 32'h4433_2211);
        for (int n = 0; n < 4; n++) begin
            rd(8'(n), 8'(17 * (n + 1)));
        end
    endtask
    task t_indexed();
        i_core.issue(IOP_OP_WRITE_X, 8'h00, 8'h04, 8'hA1);
        i_core.issue(IOP_OP_WRITE_X, 8'h00, 8'h05, 8'hB2);
        i_core.issue(IOP_OP_WRITE_X, 8'h03, 8'h03, 8'hC3);
        i_core.issue(IOP_OP_WRITE_X, 8'h00, 8'h07, 8'hD4);
        i_core.issue(IOP_OP_WRITE_X, 8'h01, 8'h01, 8'h5E);
        i_core.issue(IOP_OP_WRITE, IOP_ADDR_P1_IRQEN, 8'h00, 8'h6B);
        i_core.issue(IOP_OP_WRITE_X, 8'h00, 8'h01, 8'h77);
        i_core.issue(IOP_OP_WRITE_X, 8'hFE, 8'h05, 8'h99);
        i_core.idle();
        check(port_irq_en, 32'hD4C3_6BA1);
        check(port_data, 32'h995E_7711);
        rd(IOP_ADDR_P0_IRQEN, IOP_UNMAPPED_RD);
        rd(IOP_ADDR_P3_DATA, 8'h99);
    endtask
    task t_unmapped();
        i_core.issue(8'h1A, 8'h00, 8'h00, 8'hEE);
        i_core.issue(IOP_OP_READ, 8'h02, 8'h00, 8'hEE);
        i_core.issue(IOP_OP_WRITE, 8'h08, 8'h00, 8'hEE);
        i_core.idle();
        check(port_data, 32'h995E_7711);
        check(port_irq_en, 32'hD4C3_6BA1);
        rd(8'h08, IOP_UNMAPPED_RD);
        rd(8'hFF, IOP_UNMAPPED_RD);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        check(port_data, {4{IOP_DATA_RESET}});
        check(port_irq_en, {4{IOP_IRQEN_RESET}});
        t_direct();
        t_indexed();
        t_unmapped();
        close_out();
    end
endmodule // io_port_register_access_test
`default_nettype wire
